// ===== tb/core_irq_model.sv
// Processor core interrupt entry model that counts pending-interrupt requests.
`timescale 1ns/1ps
module core_irq_model
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic irqSummaryFlag,
   output logic [7:0] entryCount
);
   logic irqSeen_reg;

   // ----------------------------------------------------------------
   // Interrupt entry
   // ----------------------------------------------------------------
   // One entry is taken per rise of the request; the handler must clear the
   // flags before the request can drop and rise again.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         irqSeen_reg <= 1'b0;
         entryCount <= 8'h00;
      end
      else
      begin
         irqSeen_reg <= irqSummaryFlag;
         if (irqSummaryFlag && !irqSeen_reg)
         begin
            entryCount <= entryCount + 8'h01;
         end
      end
   end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the metering interrupt status and enable block.
`timescale 1ns/1ps
module testbench
   import metering_irq_pkg::*;
;
   typedef struct packed {
      sfr_byte_t addr;
      sfr_byte_t flag;
      logic sum;
   } row_t;

   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] sfrAddr = 8'h00;
   logic sfrWrite = 1'b0;
   logic sfrRead = 1'b0;
   logic [7:0] sfrWdata = 8'h00;
   logic [7:0] sfrRdata;
   logic [1:0] signNeg = 2'b00;
   logic [1:0] edgeSel = 2'b00;
   logic [19:0] ev = 20'h00000;
   logic irqSummaryFlag;
   logic [7:0] entryCount;
   logic [7:0] entries;
   sfr_byte_t want;
   int fail_count = 0;
   int total_checks = 0;
   int cycles = 0;
   int i;
   row_t rows [0:19] = '{
      '{8'hdc, 8'h20, 1'b1}, '{8'hdc, 8'h04, 1'b1}, '{8'hdc, 8'h04, 1'b1},
      '{8'hdc, 8'h02, 1'b1}, '{8'hdc, 8'h01, 1'b1},
      '{8'hdd, 8'h40, 1'b1}, '{8'hdd, 8'h80, 1'b1},
      '{8'hdd, 8'h20, 1'b1}, '{8'hdd, 8'h10, 1'b1}, '{8'hdd, 8'h08, 1'b1},
      '{8'hdd, 8'h04, 1'b1}, '{8'hdd, 8'h02, 1'b1}, '{8'hdd, 8'h01, 1'b1},
      '{8'hde, 8'h20, 1'b1}, '{8'hde, 8'h10, 1'b1}, '{8'hde, 8'h08, 1'b1},
      '{8'hde, 8'h04, 1'b1}, '{8'hde, 8'h02, 1'b1}, '{8'hde, 8'h01, 1'b1},
      '{8'hde, 8'h80, 1'b0}
   };

   metering_irq_status_enable uut (.core_clk(core_clk), .reset(reset), .sfrAddr(sfrAddr),
      .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
      .activeSignNeg(signNeg[0]), .reactiveSignNeg(signNeg[1]),
      .activeSignEdgeSel(edgeSel[0]), .reactiveSignEdgeSel(edgeSel[1]),
      .faultModeChangeEvent(ev[0]), .apparentNoloadEvent(ev[1]),
      .irmsNoloadEnterEvent(ev[2]), .reactiveNoloadEvent(ev[3]), .activeNoloadEvent(ev[4]),
      .pulseOutOne(ev[5]), .pulseOutTwo(ev[6]), .apparentEnergyOverflowEvent(ev[7]),
      .reactiveEnergyOverflowEvent(ev[8]), .activeEnergyOverflowEvent(ev[9]),
      .apparentEnergyHalffullEvent(ev[10]), .reactiveEnergyHalffullEvent(ev[11]),
      .activeEnergyHalffullEvent(ev[12]), .waveformReadyEvent(ev[13]),
      .currentPeakEvent(ev[14]), .voltagePeakEvent(ev[15]), .cycleAccumDoneEvent(ev[16]),
      .zeroCrossTimeoutEvent(ev[17]), .zeroCrossEvent(ev[18]), .softResetDone(ev[19]),
      .irqSummaryFlag(irqSummaryFlag));

   core_irq_model partner (.core_clk(core_clk), .reset(reset),
      .irqSummaryFlag(irqSummaryFlag), .entryCount(entryCount));

   always #2 core_clk = ~core_clk;

   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         fail_count = fail_count + 1;
         $display("ERROR %0t run did not complete", $time);
         finish_test();
      end
   end

   // ----------------------------------------------------------------
   // Bench tasks
   // ----------------------------------------------------------------
   task automatic check(input sfr_byte_t seen, input sfr_byte_t exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR %0t got %h expected %h", $time, seen, exp);
      end
   endtask

   // Each transfer ends with one idle cycle so a strobe never toggles twice at once.
   task automatic wr(input sfr_byte_t a, input sfr_byte_t d);
      sfrAddr = a;
      sfrWdata = d;
      sfrWrite = 1'b1;
      @(negedge core_clk);
      sfrWrite = 1'b0;
      @(negedge core_clk);
   endtask

   task automatic rdChk(input sfr_byte_t a, input sfr_byte_t exp);
      sfrAddr = a;
      sfrRead = 1'b1;
      @(negedge core_clk);
      sfrRead = 1'b0;
      check(sfrRdata, exp);
      @(negedge core_clk);
   endtask

   task automatic sumChk(input logic exp);
      check({7'h00, irqSummaryFlag}, {7'h00, exp});
   endtask

   task automatic pulse(input int k);
      ev[k] = 1'b1;
      @(negedge core_clk);
      ev[k] = 1'b0;
   endtask

   task automatic endTest(input string name);
      $display("test %s finished at %0t", name, $time);
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (3) @(negedge core_clk);
      reset = 1'b0;
      for (i = 0; i < 6; i++)
      begin
         rdChk(8'hd9 + i[7:0], (i == 5) ? 8'h80 : 8'h00);
      end
      sumChk(1'b0);
      wr(8'hd9, 8'hff);
      wr(8'hda, 8'hff);
      wr(8'hdb, 8'hff);
      wr(8'he0, 8'h55);
      rdChk(8'hd9, 8'h3f);
      rdChk(8'hda, 8'hff);
      rdChk(8'hdb, 8'h3f);
      rdChk(8'he0, 8'h00);
      wr(8'hde, 8'h00);
      wr(8'hdc, 8'hff);
      rdChk(8'hde, 8'h00);
      rdChk(8'hdc, 8'h00);
      endTest("reset and access");
      for (i = 0; i < 20; i++)
      begin
         entries = entryCount;
         pulse(i);
         sumChk(rows[i].sum);
         want = rows[i].flag | ((rows[i].addr == 8'hdc) ? 8'h80 : 8'h00);
         rdChk(rows[i].addr, want);
         check(entryCount - entries, {7'h00, rows[i].sum});
         wr(rows[i].addr, 8'h00);
         sumChk(1'b0);
      end
      endTest("event table");
      wr(8'hd9, 8'h00);
      wr(8'hda, 8'h00);
      wr(8'hdb, 8'h00);
      pulse(0);
      pulse(5);
      pulse(18);
      repeat (10) @(negedge core_clk);
      sumChk(1'b0);
      rdChk(8'hdd, 8'h40);
      wr(8'hdd, 8'h00);
      wr(8'hdb, 8'h01);
      sumChk(1'b1);
      wr(8'hd9, 8'h20);
      wr(8'hde, 8'h00);
      sumChk(1'b1);
      rdChk(8'hdc, 8'ha0);
      ev[18] = 1'b1;
      wr(8'hdc, 8'h00);
      ev[18] = 1'b0;
      sumChk(1'b1);
      rdChk(8'hde, 8'h01);
      wr(8'hde, 8'h00);
      sumChk(1'b0);
      fork
         pulse(13);
         wr(8'hde, 8'h00);
      join
      rdChk(8'hde, 8'h20);
      wr(8'hde, 8'h00);
      endTest("masking");
      wr(8'hdb, 8'h00);
      wr(8'hd9, 8'h18);
      for (i = 0; i < 2; i++)
      begin
         signNeg[i] = 1'b1;
         repeat (4) @(negedge core_clk);
         rdChk(8'hdc, 8'h80 | (8'h08 << i));
         wr(8'hdc, 8'h00);
         sumChk(1'b0);
         signNeg[i] = 1'b0;
         repeat (4) @(negedge core_clk);
         edgeSel[i] = 1'b1;
         rdChk(8'hdc, 8'h00);
         signNeg[i] = 1'b1;
         repeat (4) @(negedge core_clk);
         rdChk(8'hdc, 8'h00);
         signNeg[i] = 1'b0;
         repeat (4) @(negedge core_clk);
         rdChk(8'hdc, 8'h80 | (8'h08 << i));
         wr(8'hdc, 8'h00);
      end
      endTest("sign change");
      wr(8'hd9, 8'h3f);
      pulse(4);
      reset = 1'b1;
      repeat (3) @(negedge core_clk);
      reset = 1'b0;
      rdChk(8'hdc, 8'h00);
      rdChk(8'hd9, 8'h00);
      rdChk(8'hde, 8'h80);
      sumChk(1'b0);
      endTest("second reset");
      finish_test();
   end
endmodule

// ===== verilog/metering_irq_map.svh
// Register offsets, field positions and reset values of the metering interrupt block.
`ifndef METERING_IRQ_MAP_SVH
`define METERING_IRQ_MAP_SVH

// ----------------------------------------------------------------
// Register offsets on the special function register port
// ----------------------------------------------------------------
`define IRQ_ENABLE_LOW_ADDR 8'hd9
`define IRQ_ENABLE_MID_ADDR 8'hda
`define IRQ_ENABLE_HIGH_ADDR 8'hdb
`define IRQ_STATUS_LOW_ADDR 8'hdc
`define IRQ_STATUS_MID_ADDR 8'hdd
`define IRQ_STATUS_HIGH_ADDR 8'hde

// ----------------------------------------------------------------
// Implemented bits of each register, indexed low, mid, high
// ----------------------------------------------------------------
`define STATUS_MASK_LOW 8'h3f
`define STATUS_MASK_MID 8'hff
`define STATUS_MASK_HIGH 8'hbf
`define ENABLE_MASK_LOW 8'h3f
`define ENABLE_MASK_MID 8'hff
`define ENABLE_MASK_HIGH 8'h3f

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define SUMMARY_BIT 7
`define RESET_DONE_BIT 7
`define ENABLE_RESET 8'h00
`define STATUS_RESET_LOW 8'h00
`define STATUS_RESET_MID 8'h00
`define STATUS_RESET_HIGH 8'h80

`endif

// ===== verilog/metering_irq_pkg.sv
// Types shared by the metering interrupt status and enable logic.
package metering_irq_pkg;

   typedef logic [7:0] sfr_byte_t;

   // Index of each register triple: low, mid, high.
   typedef enum logic [1:0] {GROUP_LOW, GROUP_MID, GROUP_HIGH} irq_group_t;

   typedef struct packed {
      logic prevNeg;
      logic pulse;
   } sign_state_t;

   typedef struct packed {
      sfr_byte_t [2:0] enable;
      sfr_byte_t [2:0] status;
      logic summary;
      sfr_byte_t rdata;
   } irq_state_t;

endpackage

// ===== verilog/metering_irq_status_enable.sv
// Metering interrupt status flags, enables and summary interrupt.
//
// Notes on behaviour
// RULE_01 - Summary bit 7 of low status is set while any enabled flag is set.
// RULE_02 - Summary bit drops by itself once all enabled flags are clear.
// RULE_03 - Low status bits 5, 4, 3: fault mode, reactive sign, active sign changes.
// RULE_04 - Low status bit 2: apparent no-load or entering current-rms no-load.
// RULE_05 - Low status bit 1 reactive no-load, bit 0 active no-load.
// RULE_06 - Mid status bits 7, 6 set on pulse two, one, even when outputs disabled.
// RULE_07 - Mid status bits 5, 4, 3: apparent, reactive, active energy overflow.
// RULE_08 - Mid status bits 2, 1, 0: apparent, reactive, active energy half full.
// RULE_09 - High status bit 7 set when any reset completes.
// RULE_10 - High status bit 5 set when fresh waveform samples are loaded.
// RULE_11 - High status bit 4 current peak, bit 3 voltage peak.
// RULE_12 - High status bit 2 set when half-cycle energy accumulation completes.
// RULE_13 - High status bit 1 set on zero crossing timeout.
// RULE_14 - High status bit 0 set on voltage zero crossing.
// RULE_15 - Low enable bits 5..0 gate low flags; bits 7..6 reserved.
// RULE_16 - Mid enable bits 7, 6 gate the pulse two and pulse one flags.
// RULE_17 - Mid enable bits 5..0 gate overflow and half-full flags.
// RULE_18 - High enable bits 5..0 gate their flags; reset-done flag has no enable.
// RULE_19 - Sign flag fires on falling sign with select 0, rising sign with select 1.
// RULE_20 - Flags stay set until software clears them by writing the status register.
`timescale 1ns/1ps
`include "metering_irq_map.svh"
module metering_irq_status_enable
   import metering_irq_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWrite,
   input wire logic sfrRead,
   input wire logic [7:0] sfrWdata,
   output logic [7:0] sfrRdata,
   input wire logic activeSignNeg,
   input wire logic reactiveSignNeg,
   input wire logic activeSignEdgeSel,
   input wire logic reactiveSignEdgeSel,
   input wire logic faultModeChangeEvent,
   input wire logic apparentNoloadEvent,
   input wire logic irmsNoloadEnterEvent,
   input wire logic reactiveNoloadEvent,
   input wire logic activeNoloadEvent,
   input wire logic pulseOutOne,
   input wire logic pulseOutTwo,
   input wire logic apparentEnergyOverflowEvent,
   input wire logic reactiveEnergyOverflowEvent,
   input wire logic activeEnergyOverflowEvent,
   input wire logic apparentEnergyHalffullEvent,
   input wire logic reactiveEnergyHalffullEvent,
   input wire logic activeEnergyHalffullEvent,
   input wire logic softResetDone,
   input wire logic waveformReadyEvent,
   input wire logic currentPeakEvent,
   input wire logic voltagePeakEvent,
   input wire logic cycleAccumDoneEvent,
   input wire logic zeroCrossTimeoutEvent,
   input wire logic zeroCrossEvent,
   output logic irqSummaryFlag
);

   localparam sfr_byte_t [2:0] StatusMask = {`STATUS_MASK_HIGH, `STATUS_MASK_MID,
                                             `STATUS_MASK_LOW};
   localparam sfr_byte_t [2:0] EnableMask = {`ENABLE_MASK_HIGH, `ENABLE_MASK_MID,
                                             `ENABLE_MASK_LOW};

   irq_state_t stateReg;
   irq_state_t stateNext;
   logic [1:0] signNeg;
   logic [1:0] signEdgeSel;
   logic [1:0] signPulse;
   sfr_byte_t [2:0] setVec;
   sfr_byte_t [2:0] enabledFlags;

   // ----------------------------------------------------------------
   // Sign change detectors, active in slot 0 and reactive in slot 1
   // ----------------------------------------------------------------
   assign signNeg = {reactiveSignNeg, activeSignNeg};
   assign signEdgeSel = {reactiveSignEdgeSel, activeSignEdgeSel};

   generate
      for (genvar gi = 0; gi < 2; gi++)
      begin : g_sign
         sign_change_detect u_sign (
            .core_clk(core_clk),
            .reset(reset),
            .signNeg(signNeg[gi]),
            .edgeSel(signEdgeSel[gi]),
            .signPulse(signPulse[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Event set vectors
   // ----------------------------------------------------------------
   always_comb
   begin
      setVec[GROUP_LOW] = {2'b00, faultModeChangeEvent, signPulse[1], signPulse[0],
                           apparentNoloadEvent | irmsNoloadEnterEvent,
                           reactiveNoloadEvent, activeNoloadEvent}; // RULE_03 RULE_04 RULE_05
      // The pulse flags ignore whether the pulse pins themselves are enabled.
      setVec[GROUP_MID] = {pulseOutTwo, pulseOutOne, apparentEnergyOverflowEvent,
                           reactiveEnergyOverflowEvent, activeEnergyOverflowEvent,
                           apparentEnergyHalffullEvent, reactiveEnergyHalffullEvent,
                           activeEnergyHalffullEvent}; // RULE_06 RULE_07 RULE_08
      setVec[GROUP_HIGH] = {softResetDone, 1'b0, waveformReadyEvent, currentPeakEvent,
                            voltagePeakEvent, cycleAccumDoneEvent, zeroCrossTimeoutEvent,
                            zeroCrossEvent}; // RULE_09 RULE_10 RULE_11 RULE_12 RULE_13 RULE_14
   end

   // ----------------------------------------------------------------
   // Register update
   // ----------------------------------------------------------------
   // A write to a status register clears the bits written as zero; a flag set in the
   // same cycle wins over its clear so no event is lost.
   always_comb
   begin
      stateNext = stateReg;
      for (int i = 0; i < 3; i++)
      begin
         if (sfrWrite && sfrAddr == `IRQ_ENABLE_LOW_ADDR + 8'(i))
         begin
            stateNext.enable[i] = sfrWdata & EnableMask[i]; // RULE_15 RULE_16 RULE_17 RULE_18
         end
         if (sfrWrite && sfrAddr == `IRQ_STATUS_LOW_ADDR + 8'(i))
         begin
            stateNext.status[i] = (stateReg.status[i] & sfrWdata | setVec[i])
                                  & StatusMask[i]; // RULE_20
         end
         else
         begin
            stateNext.status[i] = (stateReg.status[i] | setVec[i]) & StatusMask[i]; // RULE_20
         end
         enabledFlags[i] = stateNext.status[i] & stateNext.enable[i];
      end
      stateNext.summary = |{enabledFlags[0], enabledFlags[1], enabledFlags[2]}; // RULE_01 RULE_02
      stateNext.rdata = stateReg.rdata;
      if (sfrRead)
      begin
         case (sfrAddr)
            `IRQ_ENABLE_LOW_ADDR: stateNext.rdata = stateReg.enable[GROUP_LOW];
            `IRQ_ENABLE_MID_ADDR: stateNext.rdata = stateReg.enable[GROUP_MID];
            `IRQ_ENABLE_HIGH_ADDR: stateNext.rdata = stateReg.enable[GROUP_HIGH];
            `IRQ_STATUS_LOW_ADDR: stateNext.rdata = {stateReg.summary,
                                                     stateReg.status[GROUP_LOW][6:0]};
            `IRQ_STATUS_MID_ADDR: stateNext.rdata = stateReg.status[GROUP_MID];
            `IRQ_STATUS_HIGH_ADDR: stateNext.rdata = stateReg.status[GROUP_HIGH];
            default: stateNext.rdata = 8'h00;
         endcase
      end
   end

   // The reset value of the high status register carries the reset-done flag.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         stateReg.enable <= {`ENABLE_RESET, `ENABLE_RESET, `ENABLE_RESET};
         stateReg.status <= {`STATUS_RESET_HIGH, `STATUS_RESET_MID,
                             `STATUS_RESET_LOW}; // RULE_09
         stateReg.summary <= 1'b0;
         stateReg.rdata <= 8'h00;
      end
      else
      begin
         stateReg <= stateNext;
      end
   end

   assign sfrRdata = stateReg.rdata;
   assign irqSummaryFlag = stateReg.summary;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   logic writeLow;
   logic writeMid;
   logic writeHigh;
   logic anyEnabled;
   assign writeLow = sfrWrite && sfrAddr == `IRQ_STATUS_LOW_ADDR;
   assign writeMid = sfrWrite && sfrAddr == `IRQ_STATUS_MID_ADDR;
   assign writeHigh = sfrWrite && sfrAddr == `IRQ_STATUS_HIGH_ADDR;
   assign anyEnabled = |{stateReg.status[0] & stateReg.enable[0],
                         stateReg.status[1] & stateReg.enable[1],
                         stateReg.status[2] & stateReg.enable[2]};

   property p_summary_set;
      (activeNoloadEvent && stateReg.enable[GROUP_LOW][0])
         |=> irqSummaryFlag && stateReg.status[GROUP_LOW][0];
   endproperty
   a_summary_set: assert property (p_summary_set) // RULE_01
      else $error("Enabled active no-load event did not raise the summary flag.");

   property p_summary_clear;
      !anyEnabled |-> !irqSummaryFlag;
   endproperty
   a_summary_clear: assert property (p_summary_clear) // RULE_02
      else $error("Summary flag stands with no enabled flag set.");

   sequence s_active_fall;
      !activeSignEdgeSel && $rose(activeSignNeg);
   endsequence
   sequence s_active_flag;
      ##2 stateReg.status[GROUP_LOW][3];
   endsequence
   property p_active_sign;
      s_active_fall |-> s_active_flag;
   endproperty
   a_active_sign: assert property (p_active_sign) // RULE_03
      else $error("Active sign change did not set its flag two cycles later.");

   property p_sign_direction;
      (activeSignEdgeSel && $stable(activeSignEdgeSel) && $rose(activeSignNeg))
         |=> !signPulse[0];
   endproperty
   a_sign_direction: assert property (p_sign_direction) // RULE_19
      else $error("Sign flag fired on the unselected transition.");

   property p_irms_noload;
      irmsNoloadEnterEvent |=> stateReg.status[GROUP_LOW][2];
   endproperty
   a_irms_noload: assert property (p_irms_noload) // RULE_04
      else $error("Current-rms no-load entry did not set low status bit 2.");

   property p_pulse_two;
      pulseOutTwo |=> stateReg.status[GROUP_MID][7];
   endproperty
   a_pulse_two: assert property (p_pulse_two) // RULE_06
      else $error("Pulse two did not set mid status bit 7.");

   property p_overflow;
      reactiveEnergyOverflowEvent |=> stateReg.status[GROUP_MID][4];
   endproperty
   a_overflow: assert property (p_overflow) // RULE_07
      else $error("Reactive energy overflow did not set mid status bit 4.");

   property p_reset_done;
      softResetDone |=> stateReg.status[GROUP_HIGH][`RESET_DONE_BIT];
   endproperty
   a_reset_done: assert property (p_reset_done) // RULE_09
      else $error("Soft reset completion did not set high status bit 7.");

   property p_zero_cross;
      zeroCrossEvent |=> stateReg.status[GROUP_HIGH][0];
   endproperty
   a_zero_cross: assert property (p_zero_cross) // RULE_14
      else $error("Zero crossing did not set high status bit 0.");

   property p_enable_reserved;
      stateReg.enable[GROUP_HIGH][7:6] == 2'b00 && stateReg.enable[GROUP_LOW][7:6] == 2'b00;
   endproperty
   a_enable_reserved: assert property (p_enable_reserved) // RULE_18
      else $error("Reserved enable bits hold a one.");

   property p_reset_flag_no_irq;
      (stateReg.status[GROUP_HIGH] == 8'h80 && stateReg.status[GROUP_LOW] == 8'h00
       && stateReg.status[GROUP_MID] == 8'h00) |-> !irqSummaryFlag;
   endproperty
   a_reset_flag_no_irq: assert property (p_reset_flag_no_irq) // RULE_18
      else $error("Reset-done flag alone raised the summary flag.");

   property p_flag_holds;
      (stateReg.status[GROUP_MID][0] && !(writeMid && !sfrWdata[0]))
         |=> stateReg.status[GROUP_MID][0];
   endproperty
   a_flag_holds: assert property (p_flag_holds) // RULE_20
      else $error("Status flag dropped without a clearing write.");

   property p_set_beats_clear;
      (writeHigh && !sfrWdata[5] && waveformReadyEvent)
         |=> stateReg.status[GROUP_HIGH][5];
   endproperty
   a_set_beats_clear: assert property (p_set_beats_clear) // RULE_10
      else $error("Waveform event lost against a clearing write.");

   property p_clear_drops_summary;
      (writeLow && sfrWdata == 8'h00 && stateReg.enable[GROUP_MID] == 8'h00
       && stateReg.enable[GROUP_HIGH] == 8'h00 && setVec[GROUP_LOW] == 8'h00)
         |=> !irqSummaryFlag;
   endproperty
   a_clear_drops_summary: assert property (p_clear_drops_summary) // RULE_02
      else $error("Summary flag stayed up after all enabled flags were cleared.");

   property p_pulse_one_gate;
      (pulseOutOne && stateReg.enable[GROUP_MID][6]) |=> irqSummaryFlag;
   endproperty
   a_pulse_one_gate: assert property (p_pulse_one_gate) // RULE_16
      else $error("Enabled pulse one did not raise the summary flag.");

   property p_zero_cross_gate;
      (zeroCrossEvent && stateReg.enable[GROUP_HIGH][0]
       && !(sfrWrite && sfrAddr == `IRQ_ENABLE_HIGH_ADDR)) |=> irqSummaryFlag;
   endproperty
   a_zero_cross_gate: assert property (p_zero_cross_gate) // RULE_18
      else $error("Enabled zero crossing did not raise the summary flag.");

   property p_enable_off;
      (stateReg.enable == '0 && !sfrWrite) |=> !irqSummaryFlag;
   endproperty
   a_enable_off: assert property (p_enable_off) // RULE_17
      else $error("Summary flag rose with every enable bit clear.");

   property p_fault_change;
      faultModeChangeEvent |=> stateReg.status[GROUP_LOW][5];
   endproperty
   a_fault_change: assert property (p_fault_change) // RULE_03
      else $error("Fault mode change did not set low status bit 5.");

   property p_reactive_noload;
      reactiveNoloadEvent |=> stateReg.status[GROUP_LOW][1];
   endproperty
   a_reactive_noload: assert property (p_reactive_noload) // RULE_05
      else $error("Reactive no-load did not set low status bit 1.");

   property p_half_full;
      apparentEnergyHalffullEvent |=> stateReg.status[GROUP_MID][2];
   endproperty
   a_half_full: assert property (p_half_full) // RULE_08
      else $error("Apparent energy half full did not set mid status bit 2.");

   property p_current_peak;
      currentPeakEvent |=> stateReg.status[GROUP_HIGH][4];
   endproperty
   a_current_peak: assert property (p_current_peak) // RULE_11
      else $error("Current peak did not set high status bit 4.");

   property p_cycle_end;
      cycleAccumDoneEvent |=> stateReg.status[GROUP_HIGH][2];
   endproperty
   a_cycle_end: assert property (p_cycle_end) // RULE_12
      else $error("Cycle accumulation end did not set high status bit 2.");

   property p_zx_timeout;
      zeroCrossTimeoutEvent |=> stateReg.status[GROUP_HIGH][1];
   endproperty
   a_zx_timeout: assert property (p_zx_timeout) // RULE_13
      else $error("Zero crossing timeout did not set high status bit 1.");

   sequence s_reactive_fall;
      !reactiveSignEdgeSel && $rose(reactiveSignNeg);
   endsequence
   sequence s_reactive_flag;
      ##2 stateReg.status[GROUP_LOW][4];
   endsequence
   property p_reactive_sign;
      s_reactive_fall |-> s_reactive_flag;
   endproperty
   a_reactive_sign: assert property (p_reactive_sign) // RULE_03
      else $error("Reactive sign change did not set its flag two cycles later.");

endmodule

// ===== verilog/sign_change_detect.sv
// Power sign transition detector with selectable direction.
`timescale 1ns/1ps
module sign_change_detect
   import metering_irq_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic signNeg,
   input wire logic edgeSel,
   output logic signPulse
);

   sign_state_t stateReg;
   sign_state_t stateNext;

   // ----------------------------------------------------------------
   // Edge selection
   // ----------------------------------------------------------------
   // With the select bit low a positive to negative move fires, with it high the reverse.
   always_comb
   begin
      stateNext = stateReg;
      stateNext.prevNeg = signNeg;
      if (edgeSel == 1'b0)
      begin
         stateNext.pulse = !stateReg.prevNeg && signNeg; // RULE_19
      end
      else
      begin
         stateNext.pulse = stateReg.prevNeg && !signNeg; // RULE_19
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         stateReg <= '0;
      end
      else
      begin
         stateReg <= stateNext;
      end
   end

   assign signPulse = stateReg.pulse;

endmodule
